// ===== sleep_wake_controller.sv
/*
 * Sleep and wake sequencer with RF power-down control and APB registers.
 * Assumes sys_rst is the chip reset taken from the active-low reset pin,
 * the oscillator and wake pins are asynchronous, and the packet handler
 * and USB core run on sys_clk.
 */
// Local design decisions: the address map and the APB slave port.
// How it works
// RULE1 - Separate power-downs for tx, rx, PLL, PA.
// RULE2 - Sleep gates nonessential power and clocks; core kept.
// RULE3 - Oscillator ticks; timer or host request wakes.
// RULE4 - Sessions wake per event, then sleep again.
// RULE5 - Transports idle asleep; host wake always honoured.
// RULE6 - Host-woken session stays awake between events.
// RULE7 - Asserted wake keeps awake; released allows sleep.
// RULE8 - Wake input polarity programmable, reset active low.
// RULE9 - Host wake output, programmable active level.
// RULE10 - Clock request asserted whenever reference needed.
// RULE11 - Low reset pin resets the whole chip.
// RULE12 - USB mode: wake input can force radio off.
// RULE13 - USB suspend seen, remote wake issued.
// RULE14 - Packet handler switches RF per packet.
// RULE15 - Low-power connection modes wake after interval.
// RULE16 - Wake input synchronised before use.
`timescale 1ns/1ns
module sleep_wake_controller (
  // Clock and chip reset.
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins facing the host and the oscillator.
  input  wire logic        device_wake_request,
  input  wire logic        low_power_osc,
  output logic             host_wake_request,
  output logic             ref_clock_request,
  // USB core status and remote wake pulse.
  input  wire logic        usb_suspend,
  output logic             usb_remote_wake,
  // Packet handler activity.
  input  wire logic        pkt_tx_active,
  input  wire logic        pkt_rx_active,
  // Transceiver power-down controls.
  output logic             rf_tx_pd,
  output logic             rf_rx_pd,
  output logic             rf_pll_pd,
  output logic             rf_pa_pd,
  // Power and clock gating of the chip.
  output logic             periph_power_off,
  output logic             periph_clock_gate,
  output logic             core_power_on,
  output logic             transport_idle,
  output logic             radio_off,
  // Interrupt to the local processor.
  output logic             irq
);
  import swc_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [CTL_WIDTH-1:0] ctrl_r;      // Control register.
  logic [TMR_WIDTH-1:0] wake_time_r; // Wake interval reload.
  logic [TMR_WIDTH-1:0] sess_int_r;  // Session period reload.
  logic [TMR_WIDTH-1:0] sess_len_r;  // Session event length.
  logic [EV_WIDTH-1:0]  int_stat_r;  // Sticky events.
  logic [EV_WIDTH-1:0]  int_mask_r;  // Interrupt mask.
  logic [EV_WIDTH-1:0]  ev_set;      // Event pulses this cycle.
  logic [1:0]           pins_sync;   // Synchronised wake and oscillator.
  logic                 osc_prev_r;  // Previous oscillator level.
  logic                 osc_tick;    // One pulse per oscillator rise.
  logic                 wake_act;    // Host wake request, active.
  logic                 sess_on;     // A periodic session is enabled.
  logic                 wr_en;       // APB write accepted.
  logic                 rd_setup;    // APB read setup cycle.
  logic                 addr_ok;     // Address is mapped.
  logic [TMR_WIDTH-1:0] wake_cnt_r;  // Wake timer countdown.
  logic [TMR_WIDTH-1:0] sess_cnt_r;  // Session period countdown.
  logic [TMR_WIDTH-1:0] ev_cnt_r;    // Session event countdown.
  logic                 wake_due;    // Wake timer expired.
  logic                 sess_due;    // Session event due.
  logic                 ev_done;     // Session event finished.
  logic                 attn;        // Host attention needed.
  logic                 susp_prev_r; // Previous USB suspend level.
  logic                 attn_prev_r; // Previous attention level.
  sleep_state_t         state_r;     // Sleep state.
  sleep_state_t         state_nxt;   // Next sleep state.

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // RULE16 wake input synchronised.
  sync_two_ff #(
    .WIDTH (2)
  ) u_pin_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .async_in ({device_wake_request, low_power_osc}),
    .sync_out (pins_sync)
  );

  // Oscillator edge detector on the synchronised level.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_prev_r <= 1'b0;
    end else begin
      osc_prev_r <= pins_sync[0];
    end
  end

  // RULE3 oscillator tick drives timers.
  assign osc_tick = pins_sync[0] & ~osc_prev_r;

  // RULE8 polarity applied to wake input.
  assign wake_act = pins_sync[1] ~^ ctrl_r[CTL_DWAKE_POL];

  // RULE15 sniff, hold and park share the timers.
  assign sess_on = ctrl_r[CTL_SCAN_EN] | ctrl_r[CTL_LP_CONN];

  // ****************************************************************
  // APB register access
  // ****************************************************************
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign addr_ok  = (paddr == OFS_CTRL) | (paddr == OFS_WAKE_TIME) |
                    (paddr == OFS_SESS_INT) | (paddr == OFS_SESS_LEN) |
                    (paddr == OFS_STATUS) | (paddr == OFS_INT_STAT) |
                    (paddr == OFS_INT_MASK);

  // The access phase always completes in one cycle.
  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~addr_ok;

  // Writable registers update in the access phase.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r      <= CTL_RESET;
      wake_time_r <= WAKE_TIME_RESET;
      sess_int_r  <= SESS_INT_RESET;
      sess_len_r  <= SESS_LEN_RESET;
      int_mask_r  <= '0;
    end else if (wr_en) begin
      case (paddr)
        OFS_CTRL:      ctrl_r      <= pwdata[CTL_WIDTH-1:0];
        OFS_WAKE_TIME: wake_time_r <= pwdata[TMR_WIDTH-1:0];
        OFS_SESS_INT:  sess_int_r  <= pwdata[TMR_WIDTH-1:0];
        OFS_SESS_LEN:  sess_len_r  <= pwdata[TMR_WIDTH-1:0];
        OFS_INT_MASK:  int_mask_r  <= pwdata[EV_WIDTH-1:0];
        default: begin
        end
      endcase
    end
  end

  // Read data is captured in the setup cycle and held for the access.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= '0;
    end else if (rd_setup) begin
      case (paddr)
        OFS_CTRL:      prdata <= {24'h000000, ctrl_r};
        OFS_WAKE_TIME: prdata <= {16'h0000, wake_time_r};
        OFS_SESS_INT:  prdata <= {16'h0000, sess_int_r};
        OFS_SESS_LEN:  prdata <= {16'h0000, sess_len_r};
        OFS_STATUS:    prdata <= {26'h0000000, radio_off, wake_act,
                                  pins_sync[1], usb_suspend, state_r};
        OFS_INT_STAT:  prdata <= {28'h0000000, int_stat_r};
        OFS_INT_MASK:  prdata <= {28'h0000000, int_mask_r};
        default:       prdata <= '0;
      endcase
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  // Sticky bits; a new event wins over a write-one clear.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_stat_r <= '0;
    end else if (wr_en && paddr == OFS_INT_STAT) begin
      int_stat_r <= (int_stat_r & ~pwdata[EV_WIDTH-1:0]) | ev_set;
    end else begin
      int_stat_r <= int_stat_r | ev_set;
    end
  end

  // Level interrupt from any unmasked pending event.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat_r & int_mask_r);
    end
  end

  // ****************************************************************
  // Oscillator timers
  // ****************************************************************
  assign wake_due = (wake_cnt_r == '0);
  assign sess_due = sess_on & osc_tick & (sess_cnt_r == '0);
  assign ev_done  = (ev_cnt_r == '0);

  // RULE3 wake timer counts while asleep.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_cnt_r <= WAKE_TIME_RESET;
    end else if (state_r != ST_SLEEP) begin
      wake_cnt_r <= wake_time_r;
    end else if (osc_tick && !wake_due) begin
      wake_cnt_r <= wake_cnt_r - 1'b1;
    end
  end

  // RULE4 session period timer, free running.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sess_cnt_r <= SESS_INT_RESET;
    end else if (!sess_on || sess_due) begin
      sess_cnt_r <= sess_int_r;
    end else if (osc_tick) begin
      sess_cnt_r <= sess_cnt_r - 1'b1;
    end
  end

  // Session event length, loaded at each event.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ev_cnt_r <= '0;
    end else if (sess_due) begin
      ev_cnt_r <= sess_len_r;
    end else if (osc_tick && !ev_done) begin
      ev_cnt_r <= ev_cnt_r - 1'b1;
    end
  end

  // ****************************************************************
  // Sleep state machine
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_ACTIVE: begin
        // RULE7 released wake allows sleep.
        if (ctrl_r[CTL_SLEEP_EN] && !wake_act && !attn &&
            (!sess_on || ev_done)) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        // RULE5 host wake honoured at once.
        if (wake_act || !ctrl_r[CTL_SLEEP_EN] || wake_due) begin
          state_nxt = ST_ACTIVE;
        end else if (sess_due) begin
          state_nxt = ST_EVENT;
        end
      end
      ST_EVENT: begin
        // RULE6 host wake keeps the chip awake.
        if (wake_act || !ctrl_r[CTL_SLEEP_EN]) begin
          state_nxt = ST_ACTIVE;
        end else if (ev_done) begin
          // RULE4 back to sleep after the event.
          state_nxt = ST_SLEEP;
        end
      end
      default: begin
        state_nxt = ST_ACTIVE;
      end
    endcase
  end

  // RULE11 chip reset returns to active.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_ACTIVE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Event pulses for the sticky status bits.
  always_comb begin
    ev_set             = '0;
    ev_set[EV_TIMER]   = (state_r == ST_SLEEP) & wake_due & ~wake_act;
    ev_set[EV_HOST]    = (state_r != ST_ACTIVE) & wake_act;
    ev_set[EV_SESSION] = sess_due;
    ev_set[EV_SUSPEND] = usb_suspend & ~susp_prev_r;
  end

  // ****************************************************************
  // Power, clock and host-facing outputs
  // ****************************************************************
  // Host attention from software or a pending unmasked event.
  assign attn = ctrl_r[CTL_HOST_ATTN] | irq;

  // RULE2 gating in sleep, core kept powered.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      periph_power_off  <= 1'b0;
      periph_clock_gate <= 1'b0;
      core_power_on     <= 1'b1;
      transport_idle    <= 1'b0;
    end else begin
      periph_power_off  <= (state_nxt == ST_SLEEP);
      periph_clock_gate <= (state_nxt == ST_SLEEP);
      core_power_on     <= 1'b1;
      // RULE5 transports idle while asleep.
      transport_idle    <= (state_nxt == ST_SLEEP);
    end
  end

  // RULE10 reference needed unless asleep.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_clock_request <= 1'b1;
    end else begin
      ref_clock_request <= (state_nxt != ST_SLEEP);
    end
  end

  // RULE9 host wake at programmed level.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      host_wake_request <= 1'b1;
    end else begin
      host_wake_request <= attn ~^ ctrl_r[CTL_HWAKE_POL];
    end
  end

  // RULE13 remote wake when attention rises in suspend.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      susp_prev_r     <= 1'b0;
      attn_prev_r     <= 1'b0;
      usb_remote_wake <= 1'b0;
    end else begin
      susp_prev_r     <= usb_suspend;
      attn_prev_r     <= attn;
      usb_remote_wake <= ctrl_r[CTL_USB_MODE] & usb_suspend &
                         attn & ~attn_prev_r;
    end
  end

  // RULE12 wake input forces radio off.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      radio_off <= 1'b0;
    end else begin
      radio_off <= ctrl_r[CTL_USB_MODE] & ctrl_r[CTL_RADIO_DIS] & wake_act;
    end
  end

  // RULE1 four separate power-downs.
  // RULE14 follow packet tx and rx activity.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rf_tx_pd  <= 1'b1;
      rf_rx_pd  <= 1'b1;
      rf_pll_pd <= 1'b1;
      rf_pa_pd  <= 1'b1;
    end else begin
      rf_tx_pd  <= radio_off | (state_r == ST_SLEEP) | ~pkt_tx_active;
      rf_rx_pd  <= radio_off | (state_r == ST_SLEEP) | ~pkt_rx_active;
      rf_pll_pd <= radio_off | (state_r == ST_SLEEP) |
                   ~(pkt_tx_active | pkt_rx_active);
      rf_pa_pd  <= radio_off | (state_r == ST_SLEEP) | ~pkt_tx_active;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  chk_rf_off_asleep : assert property ( // RULE1
    @(posedge sys_clk) disable iff (sys_rst)
    (state_r == ST_SLEEP) |=> rf_tx_pd && rf_rx_pd && rf_pll_pd && rf_pa_pd)
    else $error("RF path powered while asleep");

  chk_sleep_gating : assert property ( // RULE2
    @(posedge sys_clk) disable iff (sys_rst)
    (state_nxt == ST_SLEEP) |=> periph_power_off && periph_clock_gate &&
                               core_power_on && transport_idle)
    else $error("Sleep gating not applied");

  chk_timer_wake : assert property ( // RULE3
    @(posedge sys_clk) disable iff (sys_rst)
    (state_r == ST_SLEEP) && wake_due |=> (state_r == ST_ACTIVE))
    else $error("Wake timer did not wake the chip");

  chk_event_return : assert property ( // RULE4
    @(posedge sys_clk) disable iff (sys_rst)
    (state_r == ST_EVENT) && ev_done && !wake_act &&
    ctrl_r[CTL_SLEEP_EN] |=> (state_r == ST_SLEEP))
    else $error("No return to sleep after event");

  chk_host_wake : assert property ( // RULE5
    @(posedge sys_clk) disable iff (sys_rst)
    (state_r != ST_ACTIVE) && wake_act |=> (state_r == ST_ACTIVE) &&
    !periph_power_off)
    else $error("Host wake request ignored");

  chk_stay_awake : assert property ( // RULE6
    @(posedge sys_clk) disable iff (sys_rst)
    (state_r == ST_ACTIVE) && wake_act |=> (state_r == ST_ACTIVE))
    else $error("Slept while wake asserted");

  chk_clk_request : assert property ( // RULE10
    @(posedge sys_clk) disable iff (sys_rst)
    (state_r != ST_SLEEP) && $past(state_r != ST_SLEEP) |-> ref_clock_request)
    else $error("Reference clock dropped while awake");

  chk_radio_off : assert property ( // RULE12
    @(posedge sys_clk) disable iff (sys_rst)
    radio_off |=> rf_tx_pd && rf_pa_pd && rf_pll_pd)
    else $error("Radio powered in radio off mode");

  chk_rf_dynamic : assert property ( // RULE14
    @(posedge sys_clk) disable iff (sys_rst)
    pkt_tx_active && !radio_off && (state_r == ST_ACTIVE) |=>
    !rf_tx_pd && !rf_pa_pd && !rf_pll_pd)
    else $error("Transmit path not powered for packet");

  chk_wake_sync : assert property ( // RULE16
    @(posedge sys_clk) disable iff (sys_rst)
    !$past(sys_rst, 2) |-> pins_sync[1] == $past(device_wake_request, 2))
    else $error("Wake input not two stages late");

endmodule : sleep_wake_controller

// ===== swc_pkg.sv
/*
 * Shared constants for the sleep and wake controller: register map,
 * control field positions, reset values and the sleep state type.
 * Assumes a 32-bit APB register bus with one register per aligned word.
 */
package swc_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL      = 8'h00; // Control bits.
  localparam logic [7:0] OFS_WAKE_TIME = 8'h04; // Sleep wake interval.
  localparam logic [7:0] OFS_SESS_INT  = 8'h08; // Session event period.
  localparam logic [7:0] OFS_SESS_LEN  = 8'h0c; // Session event length.
  localparam logic [7:0] OFS_STATUS    = 8'h10; // Live state, read only.
  localparam logic [7:0] OFS_INT_STAT  = 8'h14; // Sticky events, W1C.
  localparam logic [7:0] OFS_INT_MASK  = 8'h18; // Interrupt enables.

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int CTL_SLEEP_EN  = 0; // Allow the sleep state.
  localparam int CTL_DWAKE_POL = 1; // Wake input active level, 1 = high.
  localparam int CTL_HWAKE_POL = 2; // Wake output active level.
  localparam int CTL_USB_MODE  = 3; // Host transport is USB.
  localparam int CTL_RADIO_DIS = 4; // Wake input acts as radio off.
  localparam int CTL_SCAN_EN   = 5; // Periodic scan session on.
  localparam int CTL_LP_CONN   = 6; // Sniff, hold or park mode on.
  localparam int CTL_HOST_ATTN = 7; // Software asks for the host.
  localparam int CTL_WIDTH     = 8; // Width of the control register.

  // Reset value of control: all off, wake input active low.
  localparam logic [CTL_WIDTH-1:0] CTL_RESET = 8'h00;

  // ****************************************************************
  // Interrupt status fields
  // ****************************************************************
  localparam int EV_TIMER   = 0; // Woken by the wake timer.
  localparam int EV_HOST    = 1; // Woken by the host request.
  localparam int EV_SESSION = 2; // A session event started.
  localparam int EV_SUSPEND = 3; // USB suspend was entered.
  localparam int EV_WIDTH   = 4; // Number of event bits.

  // Timer widths and default reload values, in oscillator ticks.
  localparam int TMR_WIDTH = 16;
  localparam logic [TMR_WIDTH-1:0] WAKE_TIME_RESET = 16'h0100;
  localparam logic [TMR_WIDTH-1:0] SESS_INT_RESET  = 16'h0040;
  localparam logic [TMR_WIDTH-1:0] SESS_LEN_RESET  = 16'h0004;

  // Sleep controller states.
  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_SLEEP,
    ST_EVENT
  } sleep_state_t;

endpackage : swc_pkg

// ===== sync_two_ff.sv
/*
 * Two flip-flop synchroniser for asynchronous levels.
 * Assumes the inputs come from pins or another clock; only the second
 * stage may be read by logic.
 */
`timescale 1ns/1ns
module sync_two_ff #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // Asynchronous input and synchronised output.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r; // First stage, read only by the second.

  // Both stages clear to zero on reset.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : sync_two_ff

// ===== host_model.sv
/*
 * Behavioural host that drives the device wake pin.
 * Assumes the bench sets want_wake and the programmed active level.
 */
`timescale 1ns/1ns
module host_model (
  // Clock.
  input  wire logic sys_clk,
  // Bench controls.
  input  wire logic want_wake,
  input  wire logic active_high,
  // Pin toward the device.
  output logic      device_wake_request
);
  // Pin starts at the inactive level of the reset polarity.
  initial device_wake_request = 1'b1;

  // drive wake level
  // The host owns the pin and moves it only after a clock edge.
  always @(posedge sys_clk) begin
    device_wake_request <= want_wake ~^ active_high;
  end
endmodule : host_model

// ===== tb_top.sv
/*
 * Self-checking bench for the sleep and wake controller.
 * Assumes the controller package and a host model are compiled first.
 */
`timescale 1ns/1ns
module tb_top;
  import swc_pkg::*;
  logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        osc, wake, pol, dwr, hwr, ref_clk, urw, tx, rx, susp;
  logic        tx_pd, rx_pd, pll_pd, pa_pd, ppo, pcg, cpo, tid, roff, irq;
  int          num_errors, check_count, cyc, i;
  integer      seed;
  sleep_wake_controller dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .device_wake_request(dwr), .low_power_osc(osc),
    .host_wake_request(hwr), .ref_clock_request(ref_clk),
    .usb_suspend(susp), .usb_remote_wake(urw), .pkt_tx_active(tx),
    .pkt_rx_active(rx), .rf_tx_pd(tx_pd), .rf_rx_pd(rx_pd),
    .rf_pll_pd(pll_pd), .rf_pa_pd(pa_pd), .periph_power_off(ppo),
    .periph_clock_gate(pcg), .core_power_on(cpo), .transport_idle(tid),
    .radio_off(roff), .irq(irq));
  host_model host (.sys_clk(sys_clk), .want_wake(wake), .active_high(pol),
    .device_wake_request(dwr));

  // Clock at 20 MHz; the oscillator ticks every four cycles.
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    osc <= cyc[1];
  end

  // Ends the run with the verdict.
  task print_verdict;
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // Timeout guard against a hung wait.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer, held until pready is sampled high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    if (pslverr === 1'b1) rd = 32'hdead0bad;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // Waits a bounded time for the sleep flag, then checks it.
  task wait_pp(input logic v);
    for (i = 0; i < 400 && ppo !== v; i++) @(posedge sys_clk);
    chk(ppo, v);
  endtask : wait_pp

  // Expected power-downs {tx, rx, pll, pa} while awake.
  function automatic logic [31:0] exp_pd(input logic t, input logic r);
    return {28'h0, ~t, ~r, ~(t | r), ~t};
  endfunction : exp_pd

  initial begin
    seed = 32'h7ef9c51e;
    {psel, penable, pwrite, paddr, pwdata, tx, rx, wake, pol, susp} = '0;
    {num_errors, check_count, cyc, osc} = '0;
    sys_rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    chk({tx_pd, rx_pd, pll_pd, pa_pd, ref_clk, cpo, ppo}, 7'h7e);
    apb(0, OFS_CTRL, 0); chk(rd, 0);
    apb(0, OFS_WAKE_TIME, 0); chk(rd, 32'h100);
    apb(0, OFS_SESS_INT, 0); chk(rd, 32'h40);
    apb(0, 8'h3c, 0); chk(rd, 32'hdead0bad);
    // Random packet activity switches the RF per packet.
    for (int k = 0; k < 8; k++) begin
      {tx, rx} <= $random(seed);
      repeat (3) @(posedge sys_clk);
      chk({tx_pd, rx_pd, pll_pd, pa_pd}, exp_pd(tx, rx));
    end
    {tx, rx} <= 2'b11;
    apb(1, OFS_WAKE_TIME, 32'hffff);
    apb(1, OFS_CTRL, 1);
    wait_pp(1);
    // The RF power-downs follow the sleep state one cycle later.
    @(posedge sys_clk);
    chk({ref_clk, tid, pcg, cpo, tx_pd, pll_pd}, 6'h1f);
    wake <= 1'b1;
    wait_pp(0);
    apb(0, OFS_INT_STAT, 0); chk(rd[1], 1);
    apb(1, OFS_INT_STAT, 32'hf);
    apb(1, OFS_WAKE_TIME, 2);
    wake <= 1'b0;
    wait_pp(1);
    wait_pp(0);
    apb(1, OFS_CTRL, 0);
    apb(0, OFS_INT_STAT, 0); chk(rd[0], 1);
    apb(1, OFS_INT_MASK, 1);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1);
    apb(1, OFS_INT_STAT, 1);
    repeat (2) @(posedge sys_clk);
    chk(irq, 0);
    apb(1, OFS_INT_MASK, 0);
    // Session events wake the chip while the timer stays long.
    apb(1, OFS_WAKE_TIME, 32'hffff);
    apb(1, OFS_SESS_INT, 4);
    apb(1, OFS_SESS_LEN, 2);
    apb(1, OFS_CTRL, 32'h21);
    repeat (200) @(posedge sys_clk);
    apb(0, OFS_INT_STAT, 0); chk(rd[2:0], 3'h4);
    // Low-power connection mode alone also runs the session timers.
    apb(1, OFS_INT_STAT, 32'hf);
    apb(1, OFS_CTRL, 32'h41);
    repeat (100) @(posedge sys_clk);
    apb(0, OFS_INT_STAT, 0); chk(rd[2:0], 3'h4);
    // A host wake during sessions keeps the chip awake between events.
    wake <= 1'b1;
    repeat (40) @(posedge sys_clk);
    chk(ppo, 0);
    // Programmed polarities of both wake pins.
    pol <= 1'b1;
    wake <= 1'b1;
    apb(1, OFS_CTRL, 32'h86);
    repeat (4) @(posedge sys_clk);
    chk({hwr, ppo}, 2'b10);
    apb(0, OFS_STATUS, 0); chk(rd[5:4], 2'b01);
    apb(1, OFS_CTRL, 32'h82);
    repeat (2) @(posedge sys_clk);
    chk(hwr, 0);
    apb(1, OFS_CTRL, 32'h1a);
    repeat (5) @(posedge sys_clk);
    chk({roff, tx_pd, rx_pd, pll_pd, pa_pd}, 5'h1f);
    chk(urw, 0);
    // Attention rising during USB suspend issues one remote wake pulse.
    susp <= 1'b1;
    apb(1, OFS_CTRL, 32'h9a);
    repeat (2) @(posedge sys_clk);
    chk(urw, 1);
    @(posedge sys_clk);
    chk(urw, 0);
    apb(0, OFS_INT_STAT, 0); chk(rd[3], 1);
    print_verdict();
  end
endmodule : tb_top
